// *** design/lmfc_align_pkg.sv ***
// constants, register map and carrier types of the lmfc alignment block
package lmfc_align_pkg;
    localparam logic [7:0] ADDR_LINK_CHECKS = 8'h30;
    localparam logic [7:0] ADDR_ERR_WINDOW = 8'h34;
    localparam logic [7:0] ADDR_LAST_ERR_LOW = 8'h38;
    localparam logic [7:0] ADDR_LAST_ERR_HIGH = 8'h39;
    localparam logic [7:0] ADDR_CONTROL = 8'h3A;
    localparam logic [7:0] ADDR_STATUS = 8'h3B;

    localparam int CHK_SUBCLASS_BIT = 1;
    localparam int CHK_INTERP_BIT = 0;
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_ARM_BIT = 6;
    localparam int CTL_CLR_STICKY_BIT = 5;
    localparam int CTL_CLR_LAST_BIT = 4;
    localparam int LAST_UNDER_BIT = 7;
    localparam int LAST_OVER_BIT = 6;
    localparam int STS_BUSY_BIT = 7;
    localparam int STS_LOCK_BIT = 3;
    localparam int STS_ROTATE_BIT = 2;
    localparam int STS_WLIM_BIT = 1;
    localparam int STS_TRIP_BIT = 0;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] WINDOW_RESET = 2'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    localparam logic [3:0] MODE_ONE_SHOT = 4'h1;
    localparam logic [3:0] MODE_CONTINUOUS = 4'h2;
    localparam logic [3:0] MODE_MONITOR = 4'h8;
    localparam logic [3:0] MODE_ONE_SHOT_MONITOR = 4'h9;

    // local multiframe period in dac clock cycles
    localparam logic [3:0] LMFC_LAST = 4'hF;
    localparam logic [3:0] LMFC_AFTER_ALIGN = 4'h1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_ADJUST = 2'b10,
        ST_MONITOR = 2'b11
    } align_state_t;

    typedef struct packed {
        logic enable;
        logic arm;
        logic clr_sticky;
        logic clr_last;
        logic [3:0] mode;
    } sync_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : lmfc_align_pkg

// *** design/lmfc_sysref_phase_align.sv ***
// lmfc to sysref phase alignment with configuration checks and sync status
`timescale 1ns/1ps
`default_nettype none
module lmfc_sysref_phase_align
    import lmfc_align_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire lmfc_align_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic sysref,
    input wire logic [2:0] link_subclass,
    input wire logic [3:0] interp_factor,
    output logic lmfc_pulse,
    output logic align_busy
);
    import lmfc_align_pkg::*;

    // registered state
    sync_ctrl_t ctrl_r, ctrl_nxt;
    logic [1:0] phase_tolerance_window_r, phase_tolerance_window_nxt;
    logic [3:0] last_phase_error_r, last_phase_error_nxt;
    logic last_error_below_flag_r, last_error_below_flag_nxt;
    logic last_error_above_flag_r, last_error_above_flag_nxt;
    logic align_rotated_sticky_r, align_rotated_sticky_nxt;
    logic align_tripped_sticky_r, align_tripped_sticky_nxt;
    logic lock_r, lock_nxt;
    logic wlim_r, wlim_nxt;
    logic bad_interp_factor_flag_r, bad_interp_factor_flag_nxt;
    logic bad_subclass_flag_r, bad_subclass_flag_nxt;
    logic armed_r, armed_nxt;
    align_state_t state_r, state_nxt;
    logic [3:0] lmfc_cnt_r, lmfc_cnt_nxt;
    logic [3:0] meas_err_r, meas_err_nxt;
    logic [2:0] sysref_sync_r, sysref_sync_nxt;
    logic sysref_level_r, sysref_level_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic lmfc_pulse_r, lmfc_pulse_nxt;
    logic busy_r, busy_nxt;

    // decoded helpers
    logic ctrl_wr;
    sync_ctrl_t ctrl_wdata;
    logic sticky_clear_strobe;
    logic last_error_clear_strobe;
    logic align_arm_strobe;
    logic sysref_rise;
    logic signed [4:0] err_s;
    logic signed [4:0] win_s;
    logic err_below;
    logic err_above;
    logic win_wr;
    logic out_of_window;

    assign ctrl_wr = reg_req.wr && (reg_req.addr == ADDR_CONTROL);
    assign ctrl_wdata = sync_ctrl_t'(reg_req.wdata);
    assign win_wr = reg_req.wr && (reg_req.addr == ADDR_ERR_WINDOW);
    // rising edges of written control bits act once
    assign sticky_clear_strobe = ctrl_wr && ctrl_wdata.clr_sticky && !ctrl_r.clr_sticky;
    assign last_error_clear_strobe = ctrl_wr && ctrl_wdata.clr_last && !ctrl_r.clr_last;
    assign align_arm_strobe = ctrl_wr && ctrl_wdata.arm && !ctrl_r.arm;
    assign sysref_rise = sysref_level_r == 1'b0 && sysref_sync_r[1] == sysref_sync_r[2]
        && sysref_sync_r[2] == 1'b1;
    // lmfc count wraps at 16, so the phase reads directly as signed four bits
    assign err_s = {meas_err_r[3], meas_err_r};
    assign win_s = {3'b000, phase_tolerance_window_r};
    assign err_below = err_s < -win_s;
    assign err_above = err_s > win_s;
    assign out_of_window = err_below || err_above;

    // register file and status next values
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        phase_tolerance_window_nxt = phase_tolerance_window_r;
        rdata_nxt = READ_ZERO;
        if (ctrl_wr)
        begin
            ctrl_nxt = ctrl_wdata;
        end
        if (win_wr)
        begin
            phase_tolerance_window_nxt = reg_req.wdata[1:0];
        end
        bad_subclass_flag_nxt = link_subclass > 3'h1;
        bad_interp_factor_flag_nxt = !(interp_factor == 4'h1 || interp_factor == 4'h2
            || interp_factor == 4'h4 || interp_factor == 4'h8);
        unique case (reg_req.addr)
            ADDR_LINK_CHECKS:
            begin
                rdata_nxt[CHK_SUBCLASS_BIT] = bad_subclass_flag_r;
                rdata_nxt[CHK_INTERP_BIT] = bad_interp_factor_flag_r;
            end
            ADDR_ERR_WINDOW:
            begin
                rdata_nxt[1:0] = phase_tolerance_window_r;
            end
            ADDR_LAST_ERR_LOW:
            begin
                rdata_nxt[3:0] = last_phase_error_r;
            end
            ADDR_LAST_ERR_HIGH:
            begin
                rdata_nxt[LAST_UNDER_BIT] = last_error_below_flag_r;
                rdata_nxt[LAST_OVER_BIT] = last_error_above_flag_r;
            end
            ADDR_CONTROL:
            begin
                rdata_nxt = ctrl_r;
            end
            ADDR_STATUS:
            begin
                rdata_nxt[STS_BUSY_BIT] = busy_r;
                rdata_nxt[STS_LOCK_BIT] = lock_r;
                rdata_nxt[STS_ROTATE_BIT] = align_rotated_sticky_r;
                rdata_nxt[STS_WLIM_BIT] = wlim_r;
                rdata_nxt[STS_TRIP_BIT] = align_tripped_sticky_r;
            end
            default:
            begin
                rdata_nxt = READ_ZERO;
            end
        endcase
    end

    // sysref synchroniser; only stages two and three are compared
    // a glitch of one edge never reaches the filtered level
    always_comb
    begin
        sysref_sync_nxt = {sysref_sync_r[1:0], sysref};
        sysref_level_nxt = sysref_level_r;
        if (sysref_sync_r[1] == sysref_sync_r[2])
        begin
            sysref_level_nxt = sysref_sync_r[2];
        end
    end

    // alignment machine
    always_comb
    begin
        state_nxt = state_r;
        armed_nxt = armed_r;
        meas_err_nxt = meas_err_r;
        lmfc_cnt_nxt = (lmfc_cnt_r == LMFC_LAST) ? 4'h0 : lmfc_cnt_r + 4'h1;
        lmfc_pulse_nxt = lmfc_cnt_nxt == 4'h0;
        last_phase_error_nxt = last_phase_error_r;
        last_error_below_flag_nxt = last_error_below_flag_r;
        last_error_above_flag_nxt = last_error_above_flag_r;
        align_rotated_sticky_nxt = align_rotated_sticky_r;
        align_tripped_sticky_nxt = align_tripped_sticky_r;
        lock_nxt = lock_r;
        wlim_nxt = wlim_r;
        // clears first so a same-cycle hardware set wins
        if (sticky_clear_strobe)
        begin
            align_rotated_sticky_nxt = 1'b0;
            align_tripped_sticky_nxt = 1'b0;
        end
        if (last_error_clear_strobe)
        begin
            last_phase_error_nxt = 4'h0;
            last_error_below_flag_nxt = 1'b0;
            last_error_above_flag_nxt = 1'b0;
        end
        // arm written together with enable is dropped: enable must lead
        if (align_arm_strobe)
        begin
            armed_nxt = 1'b1;
        end
        if (!ctrl_r.enable)
        begin
            state_nxt = ST_IDLE;
            armed_nxt = 1'b0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    if (armed_r || ctrl_r.mode == MODE_MONITOR)
                    begin
                        state_nxt = ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (sysref_rise)
                    begin
                        meas_err_nxt = lmfc_cnt_r;
                        align_tripped_sticky_nxt = armed_r ? 1'b1 : align_tripped_sticky_nxt;
                        armed_nxt = 1'b0;
                        state_nxt = ST_ADJUST;
                    end
                end
                ST_ADJUST:
                begin
                    // lock and outside-window follow every measurement, monitor included
                    wlim_nxt = out_of_window;
                    lock_nxt = !out_of_window;
                    if (out_of_window && ctrl_r.mode != MODE_MONITOR)
                    begin
                        // measurement was taken one cycle ago: keep the counter on phase
                        lmfc_cnt_nxt = LMFC_AFTER_ALIGN + 4'h1;
                        lmfc_pulse_nxt = 1'b0;
                        last_phase_error_nxt = meas_err_r;
                        last_error_below_flag_nxt = err_below;
                        last_error_above_flag_nxt = err_above;
                        align_rotated_sticky_nxt = 1'b1;
                    end
                    unique case (ctrl_r.mode)
                        MODE_CONTINUOUS: state_nxt = ST_WAIT;
                        MODE_MONITOR: state_nxt = ST_MONITOR;
                        MODE_ONE_SHOT_MONITOR: state_nxt = ST_MONITOR;
                        default: state_nxt = ST_IDLE;
                    endcase
                end
                ST_MONITOR:
                begin
                    // watch only here; in one-shot monitor mode the following adjust still rotates the counter
                    if (sysref_rise)
                    begin
                        meas_err_nxt = lmfc_cnt_r;
                        state_nxt = ST_ADJUST;
                    end
                end
            endcase
            if (ctrl_r.mode == MODE_MONITOR && state_r == ST_ADJUST)
            begin
                state_nxt = ST_MONITOR;
            end
        end
        busy_nxt = state_nxt == ST_WAIT || state_nxt == ST_ADJUST;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // status bits idle low, so a reset reads as no event
            ctrl_r <= CONTROL_RESET;
            phase_tolerance_window_r <= WINDOW_RESET;
            last_phase_error_r <= 4'h0;
            last_error_below_flag_r <= 1'b0;
            last_error_above_flag_r <= 1'b0;
            align_rotated_sticky_r <= 1'b0;
            align_tripped_sticky_r <= 1'b0;
            lock_r <= 1'b0;
            wlim_r <= 1'b0;
            bad_interp_factor_flag_r <= 1'b0;
            bad_subclass_flag_r <= 1'b0;
            armed_r <= 1'b0;
            state_r <= ST_IDLE;
            lmfc_cnt_r <= 4'h0;
            meas_err_r <= 4'h0;
            sysref_sync_r <= 3'b000;
            sysref_level_r <= 1'b0;
            rdata_r <= READ_ZERO;
            lmfc_pulse_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            phase_tolerance_window_r <= phase_tolerance_window_nxt;
            last_phase_error_r <= last_phase_error_nxt;
            last_error_below_flag_r <= last_error_below_flag_nxt;
            last_error_above_flag_r <= last_error_above_flag_nxt;
            align_rotated_sticky_r <= align_rotated_sticky_nxt;
            align_tripped_sticky_r <= align_tripped_sticky_nxt;
            lock_r <= lock_nxt;
            wlim_r <= wlim_nxt;
            bad_interp_factor_flag_r <= bad_interp_factor_flag_nxt;
            bad_subclass_flag_r <= bad_subclass_flag_nxt;
            armed_r <= armed_nxt;
            state_r <= state_nxt;
            lmfc_cnt_r <= lmfc_cnt_nxt;
            meas_err_r <= meas_err_nxt;
            sysref_sync_r <= sysref_sync_nxt;
            sysref_level_r <= sysref_level_nxt;
            rdata_r <= rdata_nxt;
            lmfc_pulse_r <= lmfc_pulse_nxt;
            busy_r <= busy_nxt;
        end
    end

    // outputs come straight from their flops
    assign reg_rdata = rdata_r;
    assign lmfc_pulse = lmfc_pulse_r;
    assign align_busy = busy_r;
endmodule : lmfc_sysref_phase_align
`default_nettype wire

// *** verif/lmfc_align_assertions.sv ***
// port-level assertions for the lmfc alignment block
`timescale 1ns/1ps
`default_nettype none
module lmfc_align_assertions
    import lmfc_align_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire lmfc_align_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic sysref,
    input wire logic [2:0] link_subclass,
    input wire logic [3:0] interp_factor,
    input wire logic lmfc_pulse,
    input wire logic align_busy
);
    logic [2:0] sub_r;
    logic [3:0] ipf_r;
    logic [7:0] ctl_r;
    logic [1:0] off_r;
    wire logic ctl_wr = reg_req.wr && reg_req.addr == ADDR_CONTROL;
    wire logic win_wr = reg_req.wr && reg_req.addr == ADDR_ERR_WINDOW;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sub_r <= 3'h0;
            ipf_r <= 4'h0;
            ctl_r <= CONTROL_RESET;
            off_r <= 2'h0;
        end
        else
        begin
            sub_r <= link_subclass;
            ipf_r <= interp_factor;
            ctl_r <= ctl_wr ? reg_req.wdata : ctl_r;
            // age of enable-off, saturating so it never wraps back
            off_r <= ctl_r[CTL_ENABLE_BIT] ? 2'h0 : off_r + {1'b0, off_r != 2'h3};
        end
    end
    a_subclass_flag: assert property (
        reg_req.addr == ADDR_LINK_CHECKS && link_subclass == sub_r
        |=> reg_rdata[CHK_SUBCLASS_BIT] == (sub_r > 3'h1)) else $error("subclass flag");
    a_interp_flag: assert property (
        reg_req.addr == ADDR_LINK_CHECKS && interp_factor == ipf_r
        |=> reg_rdata[CHK_INTERP_BIT] == !(ipf_r inside {4'h1, 4'h2, 4'h4, 4'h8}))
        else $error("interp flag");
    a_window_back: assert property (
        win_wr ##1 (reg_req.addr == ADDR_ERR_WINDOW && !reg_req.wr)
        |=> reg_rdata == {6'h00, $past(reg_req.wdata[1:0], 2)}) else $error("window");
    a_control_back: assert property (
        ctl_wr ##1 (reg_req.addr == ADDR_CONTROL && !reg_req.wr)
        |=> reg_rdata == $past(reg_req.wdata, 2)) else $error("control");
    a_arm_busy: assert property (
        ctl_wr && ctl_r[7] && !ctl_r[6] && reg_req.wdata[7:6] == 2'b11
        && reg_req.wdata[3:0] != MODE_MONITOR |-> ##[1:4] align_busy) else $error("arm");
    a_off_idle: assert property (off_r == 2'h3 |-> !align_busy) else $error("off");
    a_oneshot_done: assert property (
        $rose(sysref) && align_busy && ctl_r[3:0] == MODE_ONE_SHOT
        |-> ##[3:9] !align_busy) else $error("one-shot end");
    a_busy_status: assert property (
        reg_req.addr == ADDR_STATUS |=> reg_rdata[STS_BUSY_BIT] == $past(align_busy))
        else $error("busy bit");
    c_sysref_taken: cover property ($rose(sysref) && align_busy);
    c_ctl_write: cover property (ctl_wr);
    c_lmfc: cover property (lmfc_pulse);
endmodule : lmfc_align_assertions
bind lmfc_sysref_phase_align lmfc_align_assertions chk (.core_clk, .sys_rst, .reg_req,
    .reg_rdata, .sysref, .link_subclass, .interp_factor, .lmfc_pulse, .align_busy);
`default_nettype wire

// *** verif/sysref_source.sv ***
// sysref timing source model
`timescale 1ns/1ps
`default_nettype none
module sysref_source
(
    input wire logic core_clk,
    output logic sysref
);
    initial sysref = 1'b0;
    // four cycles wide so the three-stage sync never misses it
    task automatic fire();
        @(negedge core_clk);
        sysref = 1'b1;
        repeat (4) @(negedge core_clk);
        sysref = 1'b0;
    endtask : fire
endmodule : sysref_source
`default_nettype wire

// *** verif/lmfc_sysref_phase_align_tb_top.sv ***
// self-checking bench for the lmfc alignment block
`timescale 1ns/1ps
`default_nettype none
module lmfc_sysref_phase_align_tb_top;
    import lmfc_align_pkg::*;
    logic core_clk;
    logic sys_rst;
    reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic sysref;
    logic [2:0] link_subclass;
    logic [3:0] interp_factor;
    logic lmfc_pulse;
    logic align_busy;
    int failures;
    int comparisons;
    // a pin raised one cycle after a seen pulse is recognised four counts on
    localparam logic [3:0] SEEN_PHASE = 4'h4;
    logic [7:0] modes [5] = '{8'h81, 8'h82, 8'h88, 8'h89, 8'h01};
    sysref_source src (.core_clk, .sysref);
    lmfc_sysref_phase_align uut (.core_clk, .sys_rst, .reg_req, .reg_rdata, .sysref,
        .link_subclass, .interp_factor, .lmfc_pulse, .align_busy);
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : compare
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req = '{addr: a, wr: 1'b1, wdata: d};
        @(negedge core_clk);
        reg_req.wr = 1'b0;
    endtask : wr
    task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] exp);
        @(negedge core_clk);
        reg_req.addr = a;
        @(negedge core_clk);
        compare(what, exp, reg_rdata & m);
    endtask : chk_reg
    function automatic logic [7:0] cfg_exp(input logic [2:0] sc, input logic [3:0] ip);
        return {6'h00, sc > 3'h1, !(ip inside {4'h1, 4'h2, 4'h4, 4'h8})};
    endfunction : cfg_exp
    // phase offset base is the fixed SEEN_PHASE, then every error follows from the delay
    task automatic run(input logic [7:0] ctl, input logic [1:0] w, input int d);
        logic [3:0] e;
        int s;
        int wi;
        logic rec;
        logic trip;
        int n;
        logic out;
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_ERR_WINDOW, {6'h00, w});
        wr(ADDR_CONTROL, ctl | 8'h30);
        wr(ADDR_CONTROL, ctl);
        chk_reg("sticky", ADDR_STATUS, 8'h05, 8'h00);
        chk_reg("err clr", ADDR_LAST_ERR_LOW, 8'hFF, 8'h00);
        chk_reg("flag clr", ADDR_LAST_ERR_HIGH, 8'hFF, 8'h00);
        wr(ADDR_CONTROL, ctl | (ctl[3:0] == MODE_MONITOR ? 8'h00 : 8'h40));
        repeat (4) @(negedge core_clk);
        compare("busy armed", {7'h00, ctl[7]}, {7'h00, align_busy});
        n = 0;
        while (lmfc_pulse !== 1'b1 && n < 40)
        begin
            @(negedge core_clk);
            n++;
        end
        compare("lmfc pulse", 8'h01, {7'h00, lmfc_pulse});
        repeat (int'(LMFC_LAST) + 1) @(negedge core_clk);
        compare("lmfc period", 8'h01, {7'h00, lmfc_pulse});
        repeat (d) @(negedge core_clk);
        src.fire();
        repeat (20) @(negedge core_clk);
        e = SEEN_PHASE + 4'(d);
        s = int'($signed(e));
        wi = int'(w);
        trip = ctl[7] && ctl[3:0] != MODE_MONITOR;
        out = s > wi || s < -wi;
        rec = trip && out;
        chk_reg("last err", ADDR_LAST_ERR_LOW, 8'hFF, rec ? {4'h0, e} : 8'h00);
        chk_reg("flags", ADDR_LAST_ERR_HIGH, 8'hFF, {rec && s < -wi, rec && s > wi, 6'h00});
        chk_reg("status", ADDR_STATUS, ctl[7] ? 8'h8F : 8'h85,
            {ctl[7] && ctl[3:0] == MODE_CONTINUOUS, 3'h0, ctl[7] && !out, rec, ctl[7] && out,
            trip});
        $display("test done ctl %h window %0d delay %0d", ctl, w, d);
    endtask : run
    initial
    begin
        failures = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        reg_req = '0;
        link_subclass = 3'h0;
        interp_factor = 4'h1;
        void'($urandom(59905));
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        chk_reg("window rst", ADDR_ERR_WINDOW, 8'hFF, {6'h00, WINDOW_RESET});
        chk_reg("control rst", ADDR_CONTROL, 8'hFF, CONTROL_RESET);
        chk_reg("status rst", ADDR_STATUS, 8'hFF, 8'h00);
        wr(ADDR_ERR_WINDOW, 8'hFF);
        chk_reg("window bits", ADDR_ERR_WINDOW, 8'hFF, 8'h03);
        wr(ADDR_LAST_ERR_LOW, 8'hFF);
        chk_reg("read only", ADDR_LAST_ERR_LOW, 8'hFF, 8'h00);
        chk_reg("unmapped", 8'h31, 8'hFF, READ_ZERO);
        for (int i = 0; i < 40; i++)
        begin
            @(negedge core_clk);
            link_subclass = i < 8 ? i[2:0] : 3'($urandom);
            interp_factor = i < 15 ? i[3:0] + 4'h1 : 4'($urandom_range(15, 1));
            chk_reg("checks", ADDR_LINK_CHECKS, 8'h03, cfg_exp(link_subclass, interp_factor));
        end
        $display("test done config checks");
        run(8'h81, 2'h0, 0);
        for (int d = 1; d < 16; d++)
            run(8'h81, 2'h0, d);
        for (int i = 0; i < 20; i++)
            run(modes[i % 5], 2'($urandom), $urandom_range(15, 0));
        tally_and_finish();
    end
    initial
    begin
        #500us;
        failures++;
        tally_and_finish();
    end
endmodule : lmfc_sysref_phase_align_tb_top
`default_nettype wire
